// file: design/spio_top.sv
/*
 what: top of the servo position and i/o object logic: gear, polarity,
 multi-turn, input image, masked outputs, object port.
 assumes: object requests on CLK_SYS; pins
 asynchronous, active high; nonvolatile storage outside.
*/
`timescale 1ns/10ps
module spio_top import spio_pkg::*; (
	input wire logic CLK_SYS, // 40 MHz system clock
	input wire logic RST_B, // sync reset, low
	input wire logic CTRL_TICK, // control cycle strobe
	input wire logic signed [31:0] ENC_DELTA, // encoder pulses this cycle
	input wire logic [1:0] ENC_BITS_SEL, // 17, 20 or 23 bit encoder
	input wire logic [2:0] ENC_TYPE, // encoder_type_param
	input wire logic signed [15:0] ENC_ABS_TURNS, // battery-held turns
	input wire logic [22:0] ENC_ABS_ANGLE, // absolute angle at start
	input wire logic BATT_LOW_A_PIN, // battery low report a
	input wire logic BATT_LOW_B_PIN, // battery low report b
	input wire logic FAULT_RESET, // fault reset pulse
	input wire logic MT_CLEAR, // multiturn_clear_op pulse
	input wire logic [8:0] DI_PINS, // input_one .. input_nine
	input wire logic REV_LIMIT_PIN, // reverse limit
	input wire logic HOME_PIN, // home signal
	input wire logic signed [31:0] SPEED_IN, // speed value
	input wire logic signed [15:0] TORQUE_IN, // torque value
	input wire logic OBJ_REQ, // object access pulse
	input wire logic OBJ_WE, // write when high
	input wire logic OBJ_SDO, // service-data access
	input wire logic [15:0] OBJ_INDEX, // object index
	input wire logic [7:0] OBJ_SUB, // object subindex
	input wire logic [31:0] OBJ_WDATA, // write data
	input wire logic NV_VALID, // stored gear values present
	input wire logic [31:0] NV_MOTOR_RES, // stored motor resolution
	input wire logic [31:0] NV_LOAD_RES, // stored load resolution
	output logic OBJ_ACK, // answer pulse
	output logic OBJ_ERR, // access refused
	output logic [31:0] OBJ_RDATA, // read data
	output logic NV_SAVE, // save request pulse
	output logic [7:0] NV_SAVE_SUB, // gear subindex saved
	output logic [31:0] NV_SAVE_DATA, // value to save
	output logic signed [31:0] POS_INTERNAL, // pulse position
	output logic signed [31:0] POS_FEEDBACK, // user position
	output logic signed [15:0] MT_COUNT, // multi-turn count
	output logic signed [31:0] SPEED_OUT, // speed after polarity
	output logic signed [15:0] TORQUE_OUT, // torque after polarity
	output logic [5:0] DO_PINS, // output_one .. output_six
	output logic MT_OVERFLOW_ALARM, // multiturn_overflow_alarm
	output logic BATT_ALARM_A, // battery_low_alarm_a
	output logic BATT_ALARM_B // battery_low_alarm_b
);
	// ----------------------------------------
	// object registers
	// ----------------------------------------
	logic [31:0] gear_motor_resolution; // pulses per gear cycle
	logic [31:0] gear_load_resolution; // user units per gear cycle
	logic [7:0] direction_polarity; // polarity byte
	logic [31:0] input_image; // sampled input image
	logic [31:0] output_data_word; // output data
	logic [31:0] output_mask_word; // output mask
	spio_ans_t ans_state; // object answer state
	// ----------------------------------------
	// synchronisers and configuration
	// ----------------------------------------
	logic [12:0] pin_meta; // first stage, read only by second
	logic [12:0] pin_sync; // second stage
	logic init_done; // start-up load taken
	logic [2:0] enc_type; // decoded type
	logic [4:0] shift; // pulses-per-turn exponent
	logic absolute; // absolute system
	logic wrap_ok; // overflow alarm suppressed
	// ----------------------------------------
	// position path
	// ----------------------------------------
	logic signed [39:0] pulse_pos; // from turn counter
	logic signed [15:0] mt_turns; // multi-turn count
	logic ovf_cond; // overflow condition
	logic ovf_alarm; // overflow alarm
	logic signed [39:0] fed_pos; // position already handed to scaler
	logic signed [39:0] user_pos; // accumulated user position
	logic div_busy; // scaler busy
	logic div_done; // scaler done pulse
	logic div_start; // scaler start
	logic div_wait; // result pending write-back
	logic signed [39:0] div_quot; // scaled change
	logic signed [39:0] div_delta; // change to scale
	logic [31:0] rd_value; // read mux
	logic rd_ok; // read address valid
	logic wr_ok; // write accepted
	// type outside 1..4 acts as type 2
	always_comb begin
		if (ENC_TYPE >= ENC_SINGLE_INC && ENC_TYPE <= ENC_ABS_NOALARM) begin
			enc_type = ENC_TYPE; // R7
		end else begin
			enc_type = ENC_MULTI_ABS;
		end
		absolute = (enc_type == ENC_MULTI_ABS) || (enc_type == ENC_ABS_NOALARM); // R7
		wrap_ok = (enc_type == ENC_ABS_NOALARM); // R10
		if (ENC_BITS_SEL == BITS_20) begin
			shift = SHIFT_20; // R3
		end else if (ENC_BITS_SEL == BITS_23) begin
			shift = SHIFT_23; // R3
		end else begin
			shift = SHIFT_17; // R3
		end
	end
	// two flip-flops per pin
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			pin_meta <= '0;
			pin_sync <= '0;
		end else begin
			pin_meta <= {BATT_LOW_B_PIN, BATT_LOW_A_PIN, HOME_PIN, REV_LIMIT_PIN, DI_PINS};
			pin_sync <= pin_meta;
		end
	end
	// first cycle after release restores saved state
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			init_done <= 1'b0;
		end else begin
			init_done <= 1'b1;
		end
	end
	// ----------------------------------------
	// multi-turn counter
	// ----------------------------------------
	spio_turns u_turns (
		.clk(CLK_SYS),
		.rst_b(RST_B),
		.tick(CTRL_TICK),
		.delta(ENC_DELTA),
		.sh(shift),
		.absolute(absolute),
		.wrap_ok(wrap_ok),
		.load(!init_done),
		.load_turns(ENC_ABS_TURNS),
		.load_angle(ENC_ABS_ANGLE),
		.clear(MT_CLEAR),
		.fault_reset(FAULT_RESET),
		.pos(pulse_pos),
		.turns(mt_turns),
		.ovf_cond(ovf_cond),
		.ovf_alarm(ovf_alarm)
	);
	// ----------------------------------------
	// gear scaling
	// ----------------------------------------
	// new pulses are batched while the scaler works; nothing is skipped
	always_comb begin
		div_delta = pulse_pos - fed_pos;
		div_start = init_done && !div_busy && !div_done && !div_wait && (div_delta != '0);
	end
	spio_gear_div #(
		.DW(POS_W),
		.MW(32)
	) u_div (
		.clk(CLK_SYS),
		.rst_b(RST_B),
		.start(div_start),
		.delta(div_delta),
		.mul(gear_load_resolution),
		.div(gear_motor_resolution),
		.busy(div_busy),
		.done(div_done),
		.quot(div_quot)
	);
	// quotient lands one cycle after done
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			fed_pos <= '0;
			user_pos <= '0;
			div_wait <= 1'b0;
		end else begin
			if (div_start) begin
				fed_pos <= pulse_pos;
			end
			div_wait <= div_done;
			if (div_wait) begin
				user_pos <= user_pos + div_quot; // R2 R18
			end
		end
	end
	// polarity on position, speed, torque
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			POS_INTERNAL <= '0;
			POS_FEEDBACK <= '0;
			MT_COUNT <= '0;
			SPEED_OUT <= '0;
			TORQUE_OUT <= '0;
		end else begin
			POS_INTERNAL <= direction_polarity[POL_POS_BIT] ? -pulse_pos[31:0] : pulse_pos[31:0]; // R5
			POS_FEEDBACK <= direction_polarity[POL_POS_BIT] ? -user_pos[31:0] : user_pos[31:0]; // R5
			MT_COUNT <= mt_turns;
			SPEED_OUT <= direction_polarity[POL_SPD_BIT] ? -SPEED_IN : SPEED_IN; // R5
			TORQUE_OUT <= direction_polarity[POL_TRQ_BIT] ? -TORQUE_IN : TORQUE_IN; // R5
		end
	end
	// ----------------------------------------
	// alarms
	// ----------------------------------------
	// battery alarms: pin level, absolute only
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			MT_OVERFLOW_ALARM <= 1'b0;
			BATT_ALARM_A <= 1'b0;
			BATT_ALARM_B <= 1'b0;
		end else begin
			MT_OVERFLOW_ALARM <= ovf_alarm; // R8 R9
			BATT_ALARM_A <= absolute && pin_sync[11]; // R11 R13
			BATT_ALARM_B <= absolute && pin_sync[12]; // R11 R13
		end
	end
	// ----------------------------------------
	// inputs and outputs, once per control cycle
	// ----------------------------------------
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			input_image <= '0;
			DO_PINS <= '0;
		end else if (CTRL_TICK) begin
			input_image <= '0;
			input_image[IMG_DI_LSB +: DI_COUNT] <= pin_sync[8:0]; // R14 R15 R19
			input_image[IMG_REV_BIT] <= pin_sync[9]; // R14 R15
			input_image[IMG_HOME_BIT] <= pin_sync[10]; // R14 R15
			// both data and mask must be one; anything else stays off
			DO_PINS <= output_data_word[DO_LSB +: DO_COUNT] & output_mask_word[DO_LSB +: DO_COUNT]; // R16 R17 R19
		end
	end
	// ----------------------------------------
	// object read decode
	// ----------------------------------------
	always_comb begin
		rd_value = '0;
		rd_ok = 1'b1;
		if (OBJ_INDEX == OBJ_POLARITY && OBJ_SUB == SUB_COUNT) begin
			rd_value = {24'h000000, direction_polarity};
		end else if (OBJ_INDEX == OBJ_GEAR && OBJ_SUB == SUB_COUNT) begin
			rd_value = REC_SUBS;
		end else if (OBJ_INDEX == OBJ_GEAR && OBJ_SUB == SUB_FIRST) begin
			rd_value = gear_motor_resolution;
		end else if (OBJ_INDEX == OBJ_GEAR && OBJ_SUB == SUB_SECOND) begin
			rd_value = gear_load_resolution;
		end else if (OBJ_INDEX == OBJ_POS_INT && OBJ_SUB == SUB_COUNT) begin
			rd_value = POS_INTERNAL;
		end else if (OBJ_INDEX == OBJ_POS_FB && OBJ_SUB == SUB_COUNT) begin
			rd_value = POS_FEEDBACK;
		end else if (OBJ_INDEX == OBJ_INPUTS && OBJ_SUB == SUB_COUNT) begin
			rd_value = input_image;
		end else if (OBJ_INDEX == OBJ_OUTPUTS && OBJ_SUB == SUB_COUNT) begin
			rd_value = REC_SUBS;
		end else if (OBJ_INDEX == OBJ_OUTPUTS && OBJ_SUB == SUB_FIRST) begin
			rd_value = output_data_word;
		end else if (OBJ_INDEX == OBJ_OUTPUTS && OBJ_SUB == SUB_SECOND) begin
			rd_value = output_mask_word;
		end else begin
			rd_ok = 1'b0; // unknown object
		end
	end
	// write acceptance: writable, value in range
	always_comb begin
		wr_ok = 1'b0;
		if (OBJ_INDEX == OBJ_POLARITY && OBJ_SUB == SUB_COUNT) begin
			wr_ok = (OBJ_WDATA == {24'h000000, POL_CCW}) || (OBJ_WDATA == {24'h000000, POL_CW}); // R6
		end else if (OBJ_INDEX == OBJ_GEAR && (OBJ_SUB == SUB_FIRST || OBJ_SUB == SUB_SECOND)) begin
			wr_ok = (OBJ_WDATA != '0); // zero would break the division
		end else if (OBJ_INDEX == OBJ_OUTPUTS && (OBJ_SUB == SUB_FIRST || OBJ_SUB == SUB_SECOND)) begin
			wr_ok = 1'b1;
		end
	end
	// ----------------------------------------
	// object registers and answer
	// ----------------------------------------
	// writes only from the idle answer state
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			gear_motor_resolution <= GEAR_MOTOR_RST; // R1
			gear_load_resolution <= GEAR_LOAD_RST; // R1
			direction_polarity <= POLARITY_RST; // R5
			output_data_word <= OUT_WORD_RST; // R16
			output_mask_word <= OUT_WORD_RST;
		end else if (!init_done) begin
			if (NV_VALID && NV_MOTOR_RES != '0 && NV_LOAD_RES != '0) begin
				gear_motor_resolution <= NV_MOTOR_RES; // R4
				gear_load_resolution <= NV_LOAD_RES; // R4
			end
		end else if (OBJ_REQ && OBJ_WE && wr_ok && !div_busy && ans_state == ANS_IDLE) begin
			if (OBJ_INDEX == OBJ_POLARITY) begin
				direction_polarity <= OBJ_WDATA[7:0] & POL_CW; // R5 R6
			end else if (OBJ_INDEX == OBJ_GEAR && OBJ_SUB == SUB_FIRST) begin
				gear_motor_resolution <= OBJ_WDATA; // R1
			end else if (OBJ_INDEX == OBJ_GEAR) begin
				gear_load_resolution <= OBJ_WDATA; // R1
			end else if (OBJ_SUB == SUB_FIRST) begin
				output_data_word <= OBJ_WDATA; // R16
			end else begin
				output_mask_word <= OBJ_WDATA; // R17
			end
		end
	end
	// answer one cycle after the request; all writes refused mid-scaling
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			ans_state <= ANS_IDLE;
			OBJ_ACK <= 1'b0;
			OBJ_ERR <= 1'b0;
			OBJ_RDATA <= '0;
			NV_SAVE <= 1'b0;
			NV_SAVE_SUB <= '0;
			NV_SAVE_DATA <= '0;
		end else begin
			OBJ_ACK <= 1'b0;
			OBJ_ERR <= 1'b0;
			NV_SAVE <= 1'b0;
			case (ans_state)
				ANS_IDLE: begin
					if (OBJ_REQ && init_done) begin
						ans_state <= ANS_BUSY;
						OBJ_ACK <= 1'b1;
						if (OBJ_WE) begin
							OBJ_ERR <= !wr_ok || div_busy;
							if (wr_ok && !div_busy && OBJ_SDO && OBJ_INDEX == OBJ_GEAR) begin
								NV_SAVE <= 1'b1; // R4
								NV_SAVE_SUB <= OBJ_SUB; // R4
								NV_SAVE_DATA <= OBJ_WDATA; // R4
							end
						end else begin
							OBJ_ERR <= !rd_ok;
							OBJ_RDATA <= rd_value;
						end
					end
				end
				ANS_BUSY: begin
					ans_state <= ANS_IDLE;
				end
				default: begin
					ans_state <= ANS_IDLE;
				end
			endcase
		end
	end
endmodule

// file: inc/spio_pkg.sv
/*
 what: constants and encodings for the servo position and i/o block.
 assumes: one clock; object access from fieldbus slave logic.
*/
// What this block does
// R1: Hold writable motor and load gear resolutions.
// R2: Feedback equals pulses times load over motor.
// R3: Encoders of 17, 20, 23 bits accepted.
// R4: Gear writes by service data saved nonvolatile.
// R5: Polarity byte inverts position, speed, torque.
// R6: Polarity accepts only values 0 or 224.
// R7: Encoder type selects incremental or absolute system.
// R8: Absolute multi-turn limited, overflow raises alarm.
// R9: Only fault reset clears overflow alarm; here any type other than 2 also clears it.
// R10: Type four wraps turns, no alarm.
// R11: Absolute system raises low battery alarm.
// R12: Absolute system restores multi-turn position at start.
// R13: Incremental starts at zero, no limits, no battery.
// R14: Input image bits map inputs, limit, home.
// R15: Image bit reads one when input active.
// R16: Output word bits 16-21 drive outputs.
// R17: Output on only when data and mask set.
// R18: Truncate scaled position, carry division remainder forward.
// R19: Refresh inputs and outputs once per control cycle.
package spio_pkg;
	// ----------------------------------------
	// object dictionary indices and subindices
	// ----------------------------------------
	localparam logic [15:0] OBJ_POLARITY = 16'h607e; // direction_polarity
	localparam logic [15:0] OBJ_GEAR = 16'h6091; // gear ratio record
	localparam logic [15:0] OBJ_POS_INT = 16'h6063; // internal pulse position
	localparam logic [15:0] OBJ_POS_FB = 16'h6064; // user feedback position
	localparam logic [15:0] OBJ_INPUTS = 16'h60fd; // input_image
	localparam logic [15:0] OBJ_OUTPUTS = 16'h60fe; // output record
	localparam logic [7:0] SUB_COUNT = 8'h00; // number of subindexes
	localparam logic [7:0] SUB_FIRST = 8'h01; // motor res / output data
	localparam logic [7:0] SUB_SECOND = 8'h02; // load res / output mask
	localparam logic [31:0] REC_SUBS = 32'h0000_0002; // records hold two entries
	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [31:0] GEAR_MOTOR_RST = 32'h0002_0000; // 131072 pulses
	localparam logic [31:0] GEAR_LOAD_RST = 32'h0000_2710; // 10000 units
	localparam logic [7:0] POLARITY_RST = 8'h00;
	localparam logic [31:0] OUT_WORD_RST = 32'h0000_0000;
	// ----------------------------------------
	// polarity byte
	// ----------------------------------------
	localparam logic [7:0] POL_CCW = 8'h00; // ccw positive
	localparam logic [7:0] POL_CW = 8'he0; // cw positive, 224
	localparam int POL_POS_BIT = 7;
	localparam int POL_SPD_BIT = 6;
	localparam int POL_TRQ_BIT = 5;
	// ----------------------------------------
	// encoder type and width
	// ----------------------------------------
	localparam logic [2:0] ENC_SINGLE_INC = 3'h1;
	localparam logic [2:0] ENC_MULTI_ABS = 3'h2;
	localparam logic [2:0] ENC_MULTI_INC = 3'h3;
	localparam logic [2:0] ENC_ABS_NOALARM = 3'h4;
	localparam logic [1:0] BITS_17 = 2'h0;
	localparam logic [1:0] BITS_20 = 2'h1;
	localparam logic [1:0] BITS_23 = 2'h2;
	localparam logic [4:0] SHIFT_17 = 5'h11;
	localparam logic [4:0] SHIFT_20 = 5'h14;
	localparam logic [4:0] SHIFT_23 = 5'h17;
	localparam logic [4:0] SHIFT_TOP = 5'h18; // 40-bit position minus 16 turn bits
	localparam int POS_W = 40; // pulse position width
	localparam logic signed [39:0] TURN_MAX = 40'sd32767;
	localparam logic signed [39:0] TURN_MIN = -40'sd32768;
	// ----------------------------------------
	// input image and output word fields
	// ----------------------------------------
	localparam int IMG_REV_BIT = 0;
	localparam int IMG_HOME_BIT = 2;
	localparam int IMG_DI_LSB = 16; // input_one .. input_nine at 16..24
	localparam int DI_COUNT = 9;
	localparam int DO_LSB = 16; // output_one .. output_six at 16..21
	localparam int DO_COUNT = 6;
	// object answer state
	typedef enum logic [1:0] {
		ANS_IDLE = 2'b01,
		ANS_BUSY = 2'b10
	} spio_ans_t;
endpackage

// file: design/spio_gear_div.sv
/*
 what: gear scaler, delta times mul over div, remainder carried.
 assumes: start only when not busy; divisor never zero.
*/
`timescale 1ns/10ps
module spio_gear_div #(
	parameter int DW = 40, // delta and quotient width
	parameter int MW = 32 // gear word width
) (
	input wire logic clk, // system clock
	input wire logic rst_b, // sync reset, low
	input wire logic start, // begin one scaling step
	input wire logic signed [DW-1:0] delta, // pulse change
	input wire logic [MW-1:0] mul, // load resolution
	input wire logic [MW-1:0] div, // motor resolution
	output logic busy, // step in progress
	output logic done, // one-cycle pulse; quot valid the cycle after
	output logic signed [DW-1:0] quot // scaled change
);
	localparam int AW = DW + MW + 1;
	localparam int CW = $clog2(AW + 1);
	logic signed [MW:0] rem_carry; // signed remainder kept between steps
	logic [AW-1:0] mag; // dividend shifting out, quotient shifting in
	logic [MW:0] r; // partial remainder
	logic neg; // sign of the dividend
	logic [CW-1:0] cnt; // steps left
	logic signed [AW-1:0] acc; // remainder plus product
	logic [MW:0] r_sh; // remainder after shift
	logic [MW:0] div_x; // divisor widened
	// ----------------------------------------
	// dividend and trial subtraction
	// ----------------------------------------
	always_comb begin
		acc = AW'(delta) * $signed(AW'(mul)) + AW'(rem_carry); // R2
		div_x = {1'b0, div};
		r_sh = {r[MW-1:0], mag[AW-1]};
	end
	// restoring division on magnitudes: truncates toward zero
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rem_carry <= '0;
			mag <= '0;
			r <= '0;
			neg <= 1'b0;
			cnt <= '0;
			busy <= 1'b0;
			done <= 1'b0;
			quot <= '0;
		end else begin
			done <= 1'b0;
			if (start && !busy) begin
				neg <= acc[AW-1];
				mag <= acc[AW-1] ? AW'(-acc) : AW'(acc);
				r <= '0;
				cnt <= CW'(AW);
				busy <= 1'b1;
			end else if (busy) begin
				if (r_sh >= div_x) begin
					r <= r_sh - div_x;
					mag <= {mag[AW-2:0], 1'b1};
				end else begin
					r <= r_sh;
					mag <= {mag[AW-2:0], 1'b0};
				end
				cnt <= cnt - 1'b1;
				if (cnt == CW'(1)) begin
					busy <= 1'b0;
					done <= 1'b1;
				end
			end else if (done) begin
				// sign restored; remainder kept so no count is lost
				quot <= neg ? DW'(-$signed(mag)) : DW'(mag); // R18
				rem_carry <= neg ? -$signed(r) : $signed(r); // R18
			end
		end
	end
endmodule

// file: design/spio_turns.sv
/*
 what: pulse position and multi-turn counter with overflow alarm.
 assumes: delta per tick well below one turn span; load pulsed once after reset.
*/
`timescale 1ns/10ps
module spio_turns import spio_pkg::*; (
	input wire logic clk, // system clock
	input wire logic rst_b, // sync reset, low
	input wire logic tick, // control cycle strobe
	input wire logic signed [31:0] delta, // encoder pulses this cycle
	input wire logic [4:0] sh, // pulses-per-turn exponent
	input wire logic absolute, // absolute system selected
	input wire logic wrap_ok, // overflow alarm suppressed
	input wire logic load, // take start position
	input wire logic signed [15:0] load_turns, // battery-held turns
	input wire logic [22:0] load_angle, // single-turn angle
	input wire logic clear, // multiturn_clear_op
	input wire logic fault_reset, // clears the alarm
	output logic signed [39:0] pos, // pulse position
	output logic signed [15:0] turns, // multi-turn count
	output logic ovf_cond, // out of range now
	output logic ovf_alarm // multiturn_overflow_alarm
);
	logic signed [39:0] next_pos; // position after this cycle
	logic signed [39:0] sum; // unwrapped sum
	logic signed [39:0] turns_ext; // full turn count
	logic [39:0] angle_mask; // low sh bits
	logic [4:0] top_sh; // shift used to fold into 16 turn bits
	logic ovf_prev; // last cycle condition
	// ----------------------------------------
	// next position
	// ----------------------------------------
	always_comb begin
		angle_mask = (40'h1 << sh) - 40'h1;
		top_sh = SHIFT_TOP - sh;
		sum = pos + 40'(delta);
		next_pos = pos;
		if (load) begin
			// absolute restarts where the battery left it, incremental at zero
			next_pos = absolute ? ((40'(load_turns) <<< sh) | 40'(load_angle)) : '0; // R12 R13
		end else if (clear) begin
			next_pos = pos & $signed(angle_mask); // keep angle, drop turns
		end else if (tick) begin
			if (absolute && wrap_ok) begin
				next_pos = (sum <<< top_sh) >>> top_sh; // R10
			end else begin
				next_pos = sum; // R13
			end
		end
		turns_ext = pos >>> sh; // R3
		ovf_cond = absolute && !wrap_ok && (turns_ext > TURN_MAX || turns_ext < TURN_MIN); // R8
	end
	// count saturates only where range is enforced
	always_comb begin
		if (ovf_cond) begin
			turns = turns_ext[39] ? 16'sh8000 : 16'sh7fff; // R8
		end else begin
			turns = turns_ext[15:0];
		end
	end
	// position register
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pos <= '0;
		end else begin
			pos <= next_pos;
		end
	end
	// alarm raised on entering overflow; set wins over fault reset
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ovf_prev <= 1'b0;
			ovf_alarm <= 1'b0;
		end else begin
			ovf_prev <= ovf_cond;
			if (ovf_cond && !ovf_prev) begin
				ovf_alarm <= 1'b1; // R8
			end else if (fault_reset || !absolute || wrap_ok) begin
				ovf_alarm <= 1'b0; // R9 R10
			end
		end
	end
endmodule

// file: dv/spio_chk.sv
/* checker: object answer timing, output refresh, alarms.
 assumes: bound to spio_top, one clock. */
`timescale 1ns/10ps
module spio_chk import spio_pkg::*; (
	input wire logic CLK_SYS, // clock
	input wire logic RST_B, // reset, low
	input wire logic CTRL_TICK, // cycle strobe
	input wire logic OBJ_REQ, // access
	input wire logic OBJ_ACK, // answer
	input wire logic OBJ_ERR, // refused
	input wire logic NV_SAVE, // save pulse
	input wire logic [5:0] DO_PINS, // outputs
	input wire logic [2:0] ENC_TYPE, // encoder type
	input wire logic BATT_LOW_A_PIN, // battery pin
	input wire logic BATT_ALARM_A, // battery alarm
	input wire logic FAULT_RESET, // fault reset
	input wire logic MT_OVERFLOW_ALARM // overflow alarm
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_B);
	ack_has_req_a: assert property (OBJ_ACK |-> $past(OBJ_REQ)) else $error("ack w/o req");
	ack_one_a: assert property (OBJ_ACK |=> !OBJ_ACK) else $error("ack too long");
	err_ack_a: assert property (OBJ_ERR |-> OBJ_ACK) else $error("err w/o ack");
	save_ok_a: assert property (NV_SAVE |-> OBJ_ACK && !OBJ_ERR) else $error("bad save");
	do_hold_a: assert property (!$past(CTRL_TICK) |-> $stable(DO_PINS)) else $error("do moved");
	batt_abs_a: assert property ((ENC_TYPE == ENC_MULTI_ABS && BATT_LOW_A_PIN) [*4]
		|=> BATT_ALARM_A) else $error("no batt alarm");
	batt_inc_a: assert property (ENC_TYPE == ENC_SINGLE_INC || ENC_TYPE == ENC_MULTI_INC
		|-> !BATT_ALARM_A) else $error("batt alarm inc");
	ovf_hold_a: assert property (MT_OVERFLOW_ALARM && !FAULT_RESET && !$past(FAULT_RESET)
		|=> MT_OVERFLOW_ALARM) else $error("alarm lost");
endmodule
bind spio_top spio_chk chk_u (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .CTRL_TICK(CTRL_TICK),
	.OBJ_REQ(OBJ_REQ), .OBJ_ACK(OBJ_ACK), .OBJ_ERR(OBJ_ERR), .NV_SAVE(NV_SAVE),
	.DO_PINS(DO_PINS), .ENC_TYPE(ENC_TYPE), .BATT_LOW_A_PIN(BATT_LOW_A_PIN),
	.BATT_ALARM_A(BATT_ALARM_A), .FAULT_RESET(FAULT_RESET),
	.MT_OVERFLOW_ALARM(MT_OVERFLOW_ALARM));

// file: dv/spio_mst.sv
/* fieldbus master model: one object access at a time.
 assumes: object port on the same clock. */
`timescale 1ns/10ps
module spio_mst (
	input wire logic clk, // clock
	input wire logic ack, // answer
	output logic req, // access pulse
	output logic we, // write
	output logic sdo, // service data
	output logic [15:0] idx, // index
	output logic [7:0] sub, // subindex
	output logic [31:0] wd, // write data
	output logic hung // no answer
);
	initial {req, we, sdo, idx, sub, wd, hung} = '0;
	// hold request until answer, or for four cycles and then flag hung
	task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] s,
		input logic [31:0] d);
		int n;
		@(posedge clk) #1 {req, we, sdo, idx, sub, wd} = {1'b1, w, 1'b1, i, s, d};
		for (n = 0; n < 4 && ack !== 1'b1; n++) @(posedge clk);
		hung = (n == 4);
		#1 req = 1'b0;
	endtask
endmodule

// file: dv/servo_position_io_objects_test.sv
/* testbench: objects, gear scaling, image and masked outputs.
 assumes: spio_top with checker bound. */
`timescale 1ns/10ps
module servo_position_io_objects_test import spio_pkg::*;;
	logic clk, rst_b, tick, bl_a, bl_b, fr, mc, rev, home, req, we, sdo, hung, ack, err, nvs;
	logic signed [31:0] dl, spd, pfb;
	logic [8:0] di;
	logic [5:0] dop;
	logic [15:0] idx;
	logic [7:0] sub, nsub;
	logic [31:0] nvm, nvl, rd, d, m, wd, nvd;
	logic [33:0] q[$], nt;
	int mismatches, checked, seed, i;
	spio_mst mst (.clk(clk), .ack(ack), .req(req), .we(we), .sdo(sdo), .idx(idx), .sub(sub),
		.wd(wd), .hung(hung));
	spio_top dut_u (.CLK_SYS(clk), .RST_B(rst_b), .CTRL_TICK(tick), .ENC_DELTA(dl),
		.ENC_BITS_SEL(2'h0), .ENC_TYPE(ENC_MULTI_ABS), .ENC_ABS_TURNS(16'sh0),
		.ENC_ABS_ANGLE(23'h0), .BATT_LOW_A_PIN(bl_a), .BATT_LOW_B_PIN(bl_b),
		.FAULT_RESET(fr), .MT_CLEAR(mc), .DI_PINS(di), .REV_LIMIT_PIN(rev), .HOME_PIN(home),
		.SPEED_IN(spd), .TORQUE_IN(spd[15:0]), .OBJ_REQ(req), .OBJ_WE(we), .OBJ_SDO(sdo),
		.OBJ_INDEX(idx), .OBJ_SUB(sub), .OBJ_WDATA(wd), .NV_VALID(1'b0), .NV_MOTOR_RES(nvm),
		.NV_LOAD_RES(nvl), .OBJ_ACK(ack), .OBJ_ERR(err), .OBJ_RDATA(rd), .NV_SAVE(nvs),
		.NV_SAVE_SUB(nsub), .NV_SAVE_DATA(nvd), .POS_INTERNAL(), .POS_FEEDBACK(pfb),
		.MT_COUNT(), .SPEED_OUT(), .TORQUE_OUT(), .DO_PINS(dop), .MT_OVERFLOW_ALARM(),
		.BATT_ALARM_A(), .BATT_ALARM_B());
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			mismatches++;
			$display("[ERR] %0t seen %h exp %h", $time, s, e);
		end
	endtask
	// note, then access
	task automatic ob(input logic w, input logic [15:0] x, input logic [7:0] s,
		input logic [31:0] v, input logic e, input logic [31:0] r);
		q.push_back({!w, e, r});
		mst.acc(w, x, s, v);
	endtask
	task automatic tk(input logic signed [31:0] v);
		@(posedge clk) #1 {tick, dl} = {1'b1, v};
		@(posedge clk) #1 tick = 1'b0;
	endtask
	task automatic results;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// oldest note against each answer
	always @(posedge clk) if (ack === 1'b1) begin
		nt = q.pop_front();
		chk({31'h0, err}, {31'h0, nt[32]});
		if (nt[33]) chk(rd, nt[31:0]);
	end
	always @(posedge hung) begin
		mismatches++;
		results;
	end
	initial begin
		seed = 49;
		{rst_b, tick, bl_a, bl_b, fr, mc, rev, home, dl, di} = '0;
		spd = $random(seed);
		nvm = $random(seed);
		nvl = $random(seed);
		repeat (2) @(posedge clk);
		#1 rst_b = 1'b1;
		repeat (2) @(posedge clk);
		ob(0, OBJ_GEAR, SUB_FIRST, 0, 0, GEAR_MOTOR_RST);
		ob(0, OBJ_GEAR, SUB_SECOND, 0, 0, GEAR_LOAD_RST);
		ob(0, OBJ_POLARITY, SUB_COUNT, 0, 0, 0);
		ob(0, OBJ_OUTPUTS, SUB_FIRST, 0, 0, OUT_WORD_RST);
		$display("test defaults done");
		// remainder carries small steps
		for (i = 0; i < 21; i++) begin
			tk(i < 20 ? 32'sd13 : 32'sd130812);
			repeat (90) @(posedge clk);
			if (i == 19) chk(pfb, 32'd19);
		end
		chk(pfb, 32'd10000);
		$display("test scaling done");
		ob(1, OBJ_POLARITY, SUB_COUNT, 32'h05, 1, 0);
		ob(1, OBJ_POLARITY, SUB_COUNT, 32'he0, 0, 0);
		ob(0, OBJ_POLARITY, SUB_COUNT, 0, 0, 32'he0);
		ob(1, OBJ_GEAR, SUB_SECOND, 0, 1, 0);
		ob(1, OBJ_GEAR, SUB_FIRST, 32'h0004_0000, 0, 0);
		chk(nvd, 32'h0004_0000);
		chk({24'h0, nsub}, 32'h1);
		ob(1, OBJ_INPUTS, SUB_COUNT, 32'h1, 1, 0);
		$display("test objects done");
		{di, rev, home, bl_a, bl_b} = $random(seed);
		d = $random(seed);
		m = $random(seed);
		ob(1, OBJ_OUTPUTS, SUB_FIRST, d, 0, 0);
		ob(1, OBJ_OUTPUTS, SUB_SECOND, m, 0, 0);
		repeat (3) tk(32'sh7fffffff);
		repeat (4) @(posedge clk);
		tk(0);
		repeat (2) @(posedge clk);
		chk({26'h0, dop}, {26'h0, d[21:16] & m[21:16]});
		ob(0, OBJ_INPUTS, SUB_COUNT, 0, 0, {7'h0, di, 13'h0, home, 1'b0, rev});
		bl_a = 1'b1;
		{fr, mc} = 2'b11;
		@(posedge clk) #1 {fr, mc} = 2'b00;
		repeat (6) @(posedge clk);
		$display("test io done");
		results;
	end
endmodule
